//--- can_fault_confinement.sv
// CAN fault confinement core with bit timing and AHB-Lite registers
//
// Notes on behaviour
// RL1: TEC above 255 enters bus-off; drivers off, silent.
// RL2: Mode 0 (reset): leave bus-off after 128 runs of 11 recessive.
// RL3: Mode 1: leave bus-off after 128 runs of 11+ recessive split by dominant bits.
// RL4: Leaving bus-off clears both error counters.
// RL5: REC is seven bits; its overflow makes the node error-passive.
// RL6: TEC is eight bits; above 127 passive, overflow gives bus-off.
// RL7: Receiver bit error during active error flag adds 8 to REC.
// RL8: Receiver seeing dominant first bit after its flag adds 8 to REC.
// RL9: Role counter plus 8 at 14th/8th dominant after flag, then each 8.
// RL10: Other receive errors (stuff, form, CRC, ack) add 1 to REC.
// RL11: Transmitter adds 8 for bit error in active flag or other errors.
// RL12: Valid frame decrements the role counter unless it is zero; with the REC overflow flag set it clears that flag instead.
// RL13: Stuff error in arbitration on recessive stuff bit leaves TEC alone.
// RL14: Passive ack error without dominant during passive flag leaves TEC.
// RL15: Lone passive transmitter repeating on ack error never reaches bus-off.
// RL16: Falling edge on idle bus is SOF and hard-syncs bit timing.
// RL17: Bit is sync (1 tq), prop 1..8, phase 1 and 2 each 1..8.
// RL18: Resync lengthens phase 1 for late edges, shortens phase 2 early.
// RL19: At most one resynchronisation per bit time.
// RL20: Sample between phase segments; next bit starts after phase 2.
// RL21: Jump width is min(4 quanta, phase setting); phase 2 at least 1.
// RL22: Software should program phase 2 above 1 to allow shortening.
// RL23: Passive node returns to active when both counters below 128.
// RL24: Active node sends dominant error flag, passive node recessive.
`timescale 1ns/1ps
`include "can_fc_map.svh"
module can_fault_confinement (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic canRx,
    output logic canTx,
    output logic canTxEn,
    input wire logic busIdle,
    input wire logic receiving,
    input wire logic transmitter,
    input wire logic txData,
    input wire logic sendingErrFlag,
    input wire logic bitErrActiveFlag,
    input wire logic dominantAfterFlag,
    input wire logic otherErr,
    input wire logic stuffErrArb,
    input wire logic ackErr,
    input wire logic passiveFlagDominant,
    input wire logic flagEnd,
    input wire logic flagWasPassive,
    input wire logic validFrame,
    output logic sampleTick,
    output logic txTick,
    output logic sampledBit,
    output logic errActive,
    output logic errPassive,
    output logic busOff,
    output logic [7:0] tecValue,
    output logic [6:0] recValue
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    can_bt_if bt();
    can_fc_pkg::fc_state_e state_reg, state_next;
    logic [31:0] ctrl_reg;
    logic [31:0] hrdata_reg;
    logic [7:0] addr_reg;
    logic wrPend_reg;
    logic [7:0] tec_reg, tec_next;
    logic [6:0] rec_reg, rec_next;
    logic recOvf_reg, recOvf_next;
    logic domArmed_reg;
    logic [4:0] domCnt_reg;
    logic [4:0] domThresh_reg;
    logic [3:0] runCnt_reg;
    logic runCounted_reg;
    logic [7:0] recovCnt_reg;
    logic accept, domInc, runHit, recovInc, recovered;
    logic tecBig, recBig, recOne;
    logic [8:0] tecSum;
    logic [7:0] recSum;
    logic [31:0] statusWord;
    logic isOff;

    ////////////////////////////////////////////////////////////////////////
    // Bit timing unit
    assign bt.prescale = ctrl_reg[`F_PRESC];
    assign bt.propLen = {1'h0, ctrl_reg[`F_PROP]} + 4'h1; // RL17
    assign bt.ph1Len = {1'h0, ctrl_reg[`F_PH1]} + 4'h1; // RL17
    assign bt.ph2Len = {1'h0, ctrl_reg[`F_PH2]} + 4'h1; // RL17
    assign bt.busIdle = busIdle & ~isOff;
    assign bt.receiving = receiving & ~isOff;
    assign bt.rxBit = canRx;

    can_bit_timing timing (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .bt(bt)
    );

    assign sampleTick = bt.sampleTick;
    assign txTick = bt.txTick;
    assign sampledBit = bt.sampledBit;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    assign accept = hsel & hready & htrans[1];
    assign hreadyout = 1'h1;
    assign hresp = 1'h0;
    assign hrdata = hrdata_reg;

    always_comb
    begin
        statusWord = 32'h0000_0000;
        statusWord[`S_TEC] = tec_reg;
        statusWord[`S_REC] = rec_reg;
        statusWord[`S_STATE] = state_reg;
        statusWord[`S_REC_OVF] = recOvf_reg;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            wrPend_reg <= 1'h0;
            addr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
        end
        else
        begin
            wrPend_reg <= accept & hwrite;
            if (accept)
                addr_reg <= haddr[7:0];
            if (accept && !hwrite)
            begin
                if (haddr[7:0] == `CTRL_OFS)
                    hrdata_reg <= ctrl_reg;
                else if (haddr[7:0] == `STAT_OFS)
                    hrdata_reg <= statusWord;
                else
                    hrdata_reg <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            ctrl_reg <= `CTRL_RST; // RL2
        else if (wrPend_reg && addr_reg == `CTRL_OFS)
            ctrl_reg[`F_CTRL_USED] <= hwdata[`F_CTRL_USED];
    end

    ////////////////////////////////////////////////////////////////////////
    // Dominant runs after an error or overload flag
    assign domInc = bt.sampleTick & domArmed_reg & ~canRx
        & ((domCnt_reg + 5'h01) == domThresh_reg); // RL9

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || isOff)
        begin
            domArmed_reg <= 1'h0;
            domCnt_reg <= 5'h00;
            domThresh_reg <= `DOM_ACTIVE;
        end
        else if (flagEnd)
        begin
            domArmed_reg <= 1'h1;
            domCnt_reg <= 5'h00;
            domThresh_reg <= flagWasPassive ? `DOM_PASSIVE : `DOM_ACTIVE; // RL9
        end
        else if (bt.sampleTick && domArmed_reg)
        begin
            if (canRx)
                domArmed_reg <= 1'h0;
            else if (domInc)
            begin
                domCnt_reg <= 5'h00;
                domThresh_reg <= `DOM_STEP; // RL9
            end
            else
                domCnt_reg <= domCnt_reg + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus-off recovery
    assign runHit = bt.sampleTick & canRx & ((runCnt_reg + 4'h1) == `RUN_LEN);
    assign recovInc = isOff & runHit
        & (~ctrl_reg[`F_MODE] | ~runCounted_reg); // RL2 RL3
    assign recovered = recovInc & ((recovCnt_reg + 8'h01) == `RECOV_CNT);

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || !isOff || recovered)
        begin
            runCnt_reg <= 4'h0;
            runCounted_reg <= 1'h0;
            recovCnt_reg <= 8'h00;
        end
        else if (bt.sampleTick)
        begin
            if (!canRx)
            begin
                runCnt_reg <= 4'h0;
                runCounted_reg <= 1'h0; // RL3
            end
            else if (runHit)
            begin
                if (!ctrl_reg[`F_MODE])
                    runCnt_reg <= 4'h0; // RL2
                runCounted_reg <= 1'h1;
                if (recovInc)
                    recovCnt_reg <= recovCnt_reg + 8'h01;
            end
            else
                runCnt_reg <= runCnt_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error counters
    assign isOff = (state_reg == can_fc_pkg::BUS_OFF);
    assign tecBig = transmitter & (bitErrActiveFlag | domInc // RL11 RL9
        | (otherErr & ~stuffErrArb // RL13
        & ~(ackErr & errPassive & ~passiveFlagDominant))); // RL14 RL15
    assign recBig = ~transmitter
        & (bitErrActiveFlag | dominantAfterFlag | domInc); // RL7 RL8 RL9
    assign recOne = ~transmitter & otherErr & ~recBig; // RL10
    assign tecSum = {1'h0, tec_reg} + {1'h0, `INC_BIG};
    assign recSum = {1'h0, rec_reg}
        + (recBig ? `INC_BIG : (recOne ? `INC_ONE : 8'h00));

    always_comb
    begin
        tec_next = tec_reg;
        rec_next = rec_reg;
        recOvf_next = recOvf_reg;
        if (isOff)
        begin
            if (recovered)
            begin
                tec_next = 8'h00; // RL4
                rec_next = 7'h00; // RL4
                recOvf_next = 1'h0;
            end
        end
        else
        begin
            if (tecBig)
                tec_next = (tecSum > `TEC_MAX) ? tec_reg : tecSum[7:0]; // RL6
            else if (validFrame && transmitter && tec_reg != 8'h00)
                tec_next = tec_reg - 8'h01; // RL12
            if (recBig || recOne)
            begin
                if (recSum > `REC_MAX)
                begin
                    rec_next = 7'(`REC_MAX); // RL5
                    recOvf_next = 1'h1; // RL5
                end
                else
                    rec_next = recSum[6:0];
            end
            else if (validFrame && !transmitter)
            begin
                if (recOvf_reg)
                    recOvf_next = 1'h0;
                else if (rec_reg != 7'h00)
                    rec_next = rec_reg - 7'h01; // RL12
            end
        end
    end

    always_comb
    begin
        if (isOff)
            state_next = recovered ? can_fc_pkg::ERR_ACTIVE
                : can_fc_pkg::BUS_OFF; // RL2 RL3
        else if (tecBig && tecSum > `TEC_MAX)
            state_next = can_fc_pkg::BUS_OFF; // RL1 RL6
        else if (tec_next > `TEC_PASSIVE || recOvf_next)
            state_next = can_fc_pkg::ERR_PASSIVE; // RL5 RL6
        else
            state_next = can_fc_pkg::ERR_ACTIVE; // RL23
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            tec_reg <= 8'h00;
            rec_reg <= 7'h00;
            recOvf_reg <= 1'h0;
            state_reg <= can_fc_pkg::ERR_ACTIVE;
        end
        else
        begin
            tec_reg <= tec_next;
            rec_reg <= rec_next;
            recOvf_reg <= recOvf_next;
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State outputs and bus drive
    assign errActive = (state_reg == can_fc_pkg::ERR_ACTIVE);
    assign errPassive = (state_reg == can_fc_pkg::ERR_PASSIVE);
    assign busOff = isOff;
    assign tecValue = tec_reg;
    assign recValue = rec_reg;
    assign canTxEn = ~isOff; // RL1
    assign canTx = isOff ? 1'h1
        : (sendingErrFlag ? ~errActive : txData); // RL1 RL24

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_off_quiet;
        @(posedge ref_clk) disable iff (!reset_n)
        isOff |-> !canTxEn && canTx;
    endproperty
    a_off_quiet: assert property (p_off_quiet) // RL1
        else $error("bus-off node drives the bus");

    property p_enter_off;
        @(posedge ref_clk) disable iff (!reset_n)
        !isOff && tecBig && tec_reg > 8'hF7 |=> isOff;
    endproperty
    a_enter_off: assert property (p_enter_off) // RL6
        else $error("TEC overflow did not give bus-off");

    property p_clear_on_exit;
        @(posedge ref_clk) disable iff (!reset_n)
        isOff ##1 errActive |-> tec_reg == 8'h00 && rec_reg == 7'h00;
    endproperty
    a_clear_on_exit: assert property (p_clear_on_exit) // RL4
        else $error("counters not cleared on leaving bus-off");

    property p_tec_passive;
        @(posedge ref_clk) disable iff (!reset_n)
        !isOff ##1 tec_reg > 8'h7F |-> errPassive || isOff;
    endproperty
    a_tec_passive: assert property (p_tec_passive) // RL6
        else $error("TEC above 127 but not passive");

    property p_rec_one;
        @(posedge ref_clk) disable iff (!reset_n)
        !isOff && recOne && rec_reg < 7'h7E
        |=> rec_reg == $past(rec_reg) + 7'h01;
    endproperty
    a_rec_one: assert property (p_rec_one) // RL10
        else $error("receive error did not add one");

    property p_tec_eight;
        @(posedge ref_clk) disable iff (!reset_n)
        !isOff && tecBig && tec_reg < 8'h70
        |=> tec_reg == $past(tec_reg) + 8'h08;
    endproperty
    a_tec_eight: assert property (p_tec_eight) // RL11
        else $error("transmit error did not add eight");

    property p_tec_dec;
        @(posedge ref_clk) disable iff (!reset_n)
        !isOff && validFrame && transmitter && !tecBig && tec_reg != 8'h00
        |=> tec_reg == $past(tec_reg) - 8'h01;
    endproperty
    a_tec_dec: assert property (p_tec_dec) // RL12
        else $error("valid frame did not decrement TEC");

    property p_arb_stuff;
        @(posedge ref_clk) disable iff (!reset_n)
        !isOff && transmitter && otherErr && stuffErrArb
        && !bitErrActiveFlag && !domInc && !validFrame |=> $stable(tec_reg);
    endproperty
    a_arb_stuff: assert property (p_arb_stuff) // RL13
        else $error("arbitration stuff error changed TEC");

    property p_lone_ack;
        @(posedge ref_clk) disable iff (!reset_n)
        errPassive && transmitter && otherErr && ackErr && !passiveFlagDominant
        && !bitErrActiveFlag && !domInc && !validFrame |=> !isOff;
    endproperty
    a_lone_ack: assert property (p_lone_ack) // RL15
        else $error("passive ack error led to bus-off");

    property p_flag_level;
        @(posedge ref_clk) disable iff (!reset_n)
        sendingErrFlag && !isOff |-> canTx == errPassive;
    endproperty
    a_flag_level: assert property (p_flag_level) // RL24
        else $error("error flag level wrong for state");
endmodule // can_fault_confinement

//--- can_fc_map.svh
// Register map, field positions and fault confinement thresholds
`ifndef CAN_FC_MAP_SVH
`define CAN_FC_MAP_SVH
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define CTRL_RST 32'h0000_0000
`define F_MODE 0
`define F_PROP 6:4
`define F_PH1 10:8
`define F_PH2 14:12
`define F_PRESC 21:16
`define F_CTRL_USED 21:0
`define S_TEC 7:0
`define S_REC 14:8
`define S_STATE 18:16
`define S_REC_OVF 19
`define TEC_PASSIVE 8'h7F
`define TEC_MAX 9'h0FF
`define REC_MAX 8'h7F
`define INC_BIG 8'h08
`define INC_ONE 8'h01
`define DOM_ACTIVE 5'h0E
`define DOM_PASSIVE 5'h08
`define DOM_STEP 5'h08
`define RUN_LEN 4'hB
`define RECOV_CNT 8'h80
`define RJW_MAX 4'h4
`define SYNC_LEN 5'h01
`endif

//--- can_fc_pkg.sv
// Types shared by the fault confinement core and the bit timing unit
package can_fc_pkg;
    typedef enum logic [2:0] {
        ERR_ACTIVE = 3'b001,
        ERR_PASSIVE = 3'b010,
        BUS_OFF = 3'b100
    } fc_state_e;
    typedef enum logic [3:0] {
        SEG_SYNC = 4'b0001,
        SEG_PROP = 4'b0010,
        SEG_PH1 = 4'b0100,
        SEG_PH2 = 4'b1000
    } seg_e;
endpackage

//--- can_bt_if.sv
// Signals between the fault confinement core and the bit timing unit
`timescale 1ns/1ps
interface can_bt_if;
    logic [5:0] prescale;
    logic [3:0] propLen;
    logic [3:0] ph1Len;
    logic [3:0] ph2Len;
    logic busIdle;
    logic receiving;
    logic rxBit;
    logic sampleTick;
    logic txTick;
    logic sampledBit;
    modport core(
        output prescale, propLen, ph1Len, ph2Len, busIdle, receiving, rxBit,
        input sampleTick, txTick, sampledBit
    );
    modport timing(
        input prescale, propLen, ph1Len, ph2Len, busIdle, receiving, rxBit,
        output sampleTick, txTick, sampledBit
    );
endinterface

//--- can_bit_timing.sv
// Bit timing: quantum divider, segments, hard and soft synchronisation
`timescale 1ns/1ps
`include "can_fc_map.svh"
module can_bit_timing (
    input wire logic ref_clk,
    input wire logic reset_n,
    can_bt_if.timing bt
);
    can_fc_pkg::seg_e seg_reg;
    logic [5:0] preCnt_reg;
    logic [4:0] segCnt_reg;
    logic [3:0] ph1Ext_reg;
    logic [3:0] ph2Cut_reg;
    logic resyncDone_reg;
    logic rxPrev_reg;
    logic sampled_reg;
    logic tqTick, fallEdge, hardSync, resync, last;
    logic [3:0] rjw;
    logic [4:0] curLen;

    assign tqTick = (preCnt_reg == bt.prescale);
    assign fallEdge = rxPrev_reg & ~bt.rxBit;
    assign hardSync = fallEdge & bt.busIdle; // RL16
    assign resync = fallEdge & bt.receiving & ~bt.busIdle & ~resyncDone_reg
        & (seg_reg != can_fc_pkg::SEG_SYNC); // RL19
    assign rjw = (bt.ph1Len < `RJW_MAX) ? bt.ph1Len : `RJW_MAX; // RL21

    always_comb
    begin
        unique case (seg_reg)
            can_fc_pkg::SEG_SYNC: curLen = `SYNC_LEN; // RL17
            can_fc_pkg::SEG_PROP: curLen = {1'h0, bt.propLen};
            can_fc_pkg::SEG_PH1: curLen = {1'h0, bt.ph1Len}
                + {1'h0, ph1Ext_reg};
            can_fc_pkg::SEG_PH2: curLen = (bt.ph2Len > ph2Cut_reg) ?
                {1'h0, bt.ph2Len - ph2Cut_reg} : `SYNC_LEN; // RL21
            default: curLen = `SYNC_LEN;
        endcase
    end
    assign last = (segCnt_reg + 5'h01) >= curLen;
    assign bt.sampleTick = tqTick & last & (seg_reg == can_fc_pkg::SEG_PH1);
    assign bt.txTick = tqTick & last & (seg_reg == can_fc_pkg::SEG_PH2)
        & ~hardSync; // RL20
    assign bt.sampledBit = sampled_reg;

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || hardSync || tqTick)
            preCnt_reg <= 6'h00;
        else
            preCnt_reg <= preCnt_reg + 6'h01;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || hardSync) // RL16
        begin
            seg_reg <= can_fc_pkg::SEG_SYNC;
            segCnt_reg <= 5'h00;
        end
        else if (tqTick && last)
        begin
            segCnt_reg <= 5'h00;
            unique case (seg_reg)
                can_fc_pkg::SEG_SYNC: seg_reg <= can_fc_pkg::SEG_PROP;
                can_fc_pkg::SEG_PROP: seg_reg <= can_fc_pkg::SEG_PH1;
                can_fc_pkg::SEG_PH1: seg_reg <= can_fc_pkg::SEG_PH2; // RL20
                can_fc_pkg::SEG_PH2: seg_reg <= can_fc_pkg::SEG_SYNC;
                default: seg_reg <= can_fc_pkg::SEG_SYNC;
            endcase
        end
        else if (tqTick)
            segCnt_reg <= segCnt_reg + 5'h01;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || hardSync || bt.txTick)
        begin
            ph1Ext_reg <= 4'h0;
            ph2Cut_reg <= 4'h0;
            resyncDone_reg <= 1'h0;
        end
        else if (resync)
        begin
            resyncDone_reg <= 1'h1; // RL19
            if (seg_reg == can_fc_pkg::SEG_PH2)
                ph2Cut_reg <= rjw; // RL18
            else
                ph1Ext_reg <= rjw; // RL18
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            rxPrev_reg <= 1'h1;
            sampled_reg <= 1'h1;
        end
        else
        begin
            rxPrev_reg <= bt.rxBit;
            if (bt.sampleTick)
                sampled_reg <= bt.rxBit; // RL20
        end
    end

    property p_sample_apart;
        @(posedge ref_clk) disable iff (!reset_n)
        bt.sampleTick |-> !bt.txTick;
    endproperty
    a_sample_apart: assert property (p_sample_apart) // RL20
        else $error("sample and transmit point coincide");

    property p_hard_sync;
        @(posedge ref_clk) disable iff (!reset_n)
        hardSync |=> seg_reg == can_fc_pkg::SEG_SYNC && segCnt_reg == 5'h00;
    endproperty
    a_hard_sync: assert property (p_hard_sync) // RL16
        else $error("hard sync did not restart bit timing");
endmodule // can_bit_timing

//--- can_bus_node_model.sv
// Far-side bus node: recessive runs split by one dominant bit
`timescale 1ns/1ps
module can_bus_node_model (
    input wire logic ref_clk,
    input wire logic txTick,
    input wire logic canTx,
    input wire logic canTxEn,
    input wire logic [5:0] runLen,
    input wire logic holdDom,
    output logic canRx
);
    logic [5:0] bitCnt = 6'h00;
    always @(posedge ref_clk)
    begin
        if (holdDom || (txTick && bitCnt == runLen))
            bitCnt <= 6'h00;
        else if (txTick)
            bitCnt <= bitCnt + 6'h01;
    end
    // Wired-AND bus; a node without drivers leaves it recessive
    assign canRx = !holdDom && (runLen == 6'h00 || bitCnt != runLen)
        && (canTx || !canTxEn);
endmodule // can_bus_node_model

//--- tb_can_fault_confinement.sv
// Testbench for the fault confinement and bit timing block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_can_fault_confinement;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, seed = 32'h485F;
    logic hreadyout, hresp, canRx, canTx, canTxEn, sampleTick, txTick;
    logic sampledBit, errActive, errPassive, busOff;
    logic [7:0] tecValue;
    logic [6:0] recValue, r;
    logic busIdle = 1'h0, transmitter = 1'h0, sendingErrFlag = 1'h0;
    logic stuffErrArb = 1'h0, ackErr = 1'h0, passiveFlagDominant = 1'h0;
    logic flagWasPassive = 1'h0, holdDom = 1'h0;
    logic [4:0] pls = 5'h00;
    logic [5:0] runLen = 6'h00, fs;
    logic [2:0] fp, fa, fb;
    int errors = 0, compares = 0, n, e;
    always #25 ref_clk = ~ref_clk;
    can_fault_confinement can_fault_confinement_inst (
        .ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .canRx, .canTx, .canTxEn, .busIdle, .receiving(1'h0),
        .transmitter, .txData(1'h1), .sendingErrFlag,
        .bitErrActiveFlag(pls[0]), .dominantAfterFlag(pls[1]),
        .otherErr(pls[2]), .stuffErrArb, .ackErr, .passiveFlagDominant,
        .flagEnd(pls[3]), .flagWasPassive, .validFrame(pls[4]),
        .sampleTick, .txTick, .sampledBit, .errActive, .errPassive,
        .busOff, .tecValue, .recValue
    );
    can_bus_node_model can_bus_node_model_inst (
        .ref_clk, .txTick, .canTx, .canTxEn, .runLen, .holdDom, .canRx
    );
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic int qs(input logic [2:0] f, input logic [5:0] s);
        return (int'(f) + 1) * (int'(s) + 1);
    endfunction
    function automatic logic [31:0] st(input logic [7:0] t,
        input logic [6:0] rc, input logic [2:0] s);
        return {13'h0, s, 1'h0, rc, t};
    endfunction
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask
    task fire(input logic [4:0] p, input logic [2:0] qf);
        @(posedge ref_clk);
        pls <= p;
        {stuffErrArb, ackErr, passiveFlagDominant} <= qf;
        @(posedge ref_clk);
        pls <= 5'h00;
        {stuffErrArb, ackErr, passiveFlagDominant} <= 3'h0;
        @(negedge ref_clk);
    endtask
    task ticks(input logic tx, input int k, output int c);
        c = 0;
        repeat (k) do
        begin
            @(posedge ref_clk);
            c++;
        end
        while ((tx ? txTick : sampleTick) !== 1'h1 && c < 100000);
    endtask
    task results;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'h1;
        ahb(1'h0, 32'h4, 32'h0);
        `CHK("status", st(8'h00, 7'h00, 3'h1), q)
        ahb(1'h0, 32'h0, 32'h0);
        `CHK("ctrl", 32'h0, q)
        ahb(1'h0, 32'h8, 32'h0);
        `CHK("unmapped", 32'h0, q)
        $display("registers done");
        repeat (4)
        begin
            seed = xs(seed);
            fp = seed[2:0];
            fa = seed[5:3] | 3'h1;
            fb = seed[8:6] | 3'h2;
            fs = {4'h0, seed[10:9]};
            ahb(1'h1, 32'h0, {10'h0, fs, 1'h0, fb, 1'h0, fa, 1'h0, fp, 4'h0});
            e = qs(fp, fs) + qs(fa, fs) + qs(3'h0, fs);
            ticks(1'h1, 2, n);
            ticks(1'h0, 1, n);
            `CHK("to sample", e, n)
            ticks(1'h1, 1, n);
            `CHK("to tx", qs(fb, fs), n)
            busIdle <= 1'h1;
            ticks(1'h0, 1, n);
            holdDom <= 1'h1;
            ticks(1'h0, 1, n);
            `CHK("hard sync", 1'h1, n >= e - 1 && n <= e + 2)
            busIdle <= 1'h0;
            holdDom <= 1'h0;
        end
        ahb(1'h1, 32'h0, 32'h0);
        $display("timing done");
        fire(5'h04, 3'h0);
        `CHK("rec other", 7'h01, recValue)
        fire(5'h01, 3'h0);
        `CHK("rec flag bit", 7'h09, recValue)
        fire(5'h02, 3'h0);
        `CHK("rec dom after", 7'h11, recValue)
        fire(5'h10, 3'h0);
        `CHK("rec valid", 7'h10, recValue)
        r = 7'h10;
        for (int p = 0; p < 2; p++)
        begin
            @(posedge ref_clk);
            flagWasPassive <= p[0];
            holdDom <= 1'h1;
            ticks(1'h0, 1, n);
            pls <= 5'h08;
            @(posedge ref_clk);
            pls <= 5'h00;
            ticks(1'h0, p ? 7 : 13, n);
            @(negedge ref_clk);
            `CHK("run early", r, recValue)
            ticks(1'h0, 1, n);
            r = r + 7'h08;
            @(negedge ref_clk);
            `CHK("run first", r, recValue)
            ticks(1'h0, 8, n);
            r = r + 7'h08;
            @(negedge ref_clk);
            `CHK("run next", r, recValue)
            @(posedge ref_clk);
            holdDom <= 1'h0;
        end
        repeat (10) fire(5'h01, 3'h0);
        `CHK("rec sat", 7'h7F, recValue)
        `CHK("rec passive", 1'h1, errPassive)
        fire(5'h10, 3'h0);
        `CHK("rec active", 1'h1, errActive)
        $display("receive counter done");
        @(posedge ref_clk);
        transmitter <= 1'h1;
        fire(5'h04, 3'h4);
        `CHK("tec arb", 8'h00, tecValue)
        for (int i = 1; i <= 16; i++)
        begin
            fire(5'h04, 3'h0);
            `CHK("tec other", 8'(8 * i), tecValue)
        end
        `CHK("tec passive", 1'h1, errPassive)
        fire(5'h04, 3'h2);
        `CHK("ack passive", 8'h80, tecValue)
        fire(5'h04, 3'h3);
        `CHK("ack dom", 8'h88, tecValue)
        repeat (9) fire(5'h10, 3'h0);
        `CHK("tec valid", 8'h7F, tecValue)
        `CHK("tec active", 1'h1, errActive)
        @(posedge ref_clk);
        sendingErrFlag <= 1'h1;
        @(negedge ref_clk);
        `CHK("active flag", 1'h0, canTx)
        fire(5'h01, 3'h0);
        `CHK("tec flag bit", 8'h87, tecValue)
        `CHK("passive flag", 1'h1, canTx)
        repeat (15) fire(5'h04, 3'h0);
        `CHK("at 255", 1'h0, busOff)
        fire(5'h04, 3'h0);
        sendingErrFlag <= 1'h0;
        `CHK("bus off", 1'h1, busOff)
        `CHK("drivers off", 1'h0, canTxEn)
        ticks(1'h0, 1407, n);
        @(negedge ref_clk);
        `CHK("still off", 1'h1, busOff)
        ticks(1'h0, 1, n);
        repeat (3) @(negedge ref_clk);
        `CHK("recovered", 1'h1, errActive)
        ahb(1'h0, 32'h4, 32'h0);
        `CHK("cleared", st(8'h00, 7'h00, 3'h1), q)
        $display("mode zero done");
        ahb(1'h1, 32'h0, 32'h1);
        @(posedge ref_clk);
        holdDom <= 1'h1;
        runLen <= 6'h16;
        repeat (33) fire(5'h04, 3'h0);
        `CHK("off again", 1'h1, busOff)
        @(posedge ref_clk);
        holdDom <= 1'h0;
        ticks(1'h0, 127 * 23, n);
        @(negedge ref_clk);
        `CHK("mode one off", 1'h1, busOff)
        ticks(1'h0, 23, n);
        @(negedge ref_clk);
        `CHK("mode one back", 1'h1, errActive)
        $display("mode one done");
        results;
    end
    // Watchdog
    initial
    begin
        #3000000;
        errors++;
        results;
    end
endmodule // tb_can_fault_confinement
